// File: hdl/ottl_consts.vh
// constants for the overtravel and torque limit block
`ifndef OTTL_CONSTS_VH
`define OTTL_CONSTS_VH
`define MAP_W            4
`define MAP_FWD_USE      4'h2
`define MAP_REV_USE      4'h3
`define MAP_NOT_USED     4'h8
`define MAP_FWD_INV      4'hB
`define MAP_REV_INV      4'hC
`define OT_MODE_SVOFF    2'h0
`define OT_MODE_DEC_ZC   2'h1
`define OT_MODE_DEC_CST  2'h2
`define SVOFF_DEC        1'h0
`define TRQ_W            10
`define TRQ_DEFAULT      10'h320
`define TRQ_ZERO         10'h000
`define SEL_W            2
`define SEL_NONE         2'h0
`define SEL_T1           2'h1
`define SEL_T2           2'h2
`define SEL_T3           2'h3
`define MON_CLT_BIT      3
`define MON_W            4
`endif

// File: hdl/ot_sync.v
// two-stage synchroniser for a pin level
`default_nettype none
module ot_sync (
  // clock and reset
  input  wire clk_i,
  input  wire rstn_i,
  // level
  input  wire d_i,
  output wire q_o
);
  reg meta_q;
  reg sync_q;
  // preset to 1: an unknown switch reads as open, the safe side
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule // ot_sync
`default_nettype wire

// File: hdl/overtravel_torque_limit.v
// overtravel stop sequencing and torque clamping for a servo drive
// limitations: a stop is only entered while the motor runs; the
// servo-off stop method itself belongs to the external stop unit,
// which reads the servo-off mode input; this block sequences around it
`include "ottl_consts.vh"
`default_nettype none
module overtravel_torque_limit (
  // clock and reset
  input  wire                    CLOCK_I,
  input  wire                    RSTN_I,
  // limit switch pins
  input  wire                    FWD_RUN_PROHIBIT_IN_I,
  input  wire                    REV_RUN_PROHIBIT_IN_I,
  // configuration
  input  wire [`MAP_W-1:0]       FWD_PROHIBIT_MAP_FIELD_I,
  input  wire [`MAP_W-1:0]       REV_PROHIBIT_MAP_FIELD_I,
  input  wire [1:0]              OVERTRAVEL_STOP_MODE_FIELD_I,
  input  wire                    SERVO_OFF_STOP_MODE_FIELD_I,
  input  wire                    TORQUE_CONTROL_I,
  input  wire [`TRQ_W-1:0]       EMERGENCY_STOP_TORQUE_I,
  input  wire [`TRQ_W-1:0]       FWD_TORQUE_LIMIT_I,
  input  wire [`TRQ_W-1:0]       REV_TORQUE_LIMIT_I,
  input  wire [`TRQ_W-1:0]       MOTOR_MAX_TORQUE_I,
  input  wire [`SEL_W-1:0]       TORQUE_FLAG_OUTPUT_SELECT_I,
  // motion state from the control loop
  input  wire                    MOTOR_RUNNING_I,
  input  wire                    MOTOR_STOPPED_I,
  input  wire                    TORQUE_REF_NEG_I,
  input  wire [`TRQ_W-1:0]       TORQUE_REF_MAG_I,
  // other output functions already allocated to the terminals
  input  wire [3:1]              OTHER_TERMINAL_FUNCS_I,
  // results
  output reg                     FWD_ALLOWED_O,
  output reg                     REV_ALLOWED_O,
  output reg                     STOP_ACTIVE_O,
  output reg                     DECEL_ACTIVE_O,
  output reg                     ZERO_CLAMP_O,
  output reg                     COAST_O,
  output reg                     SERVO_OFF_STOP_O,
  output reg  [`TRQ_W-1:0]       STOP_TORQUE_O,
  output reg                     TORQUE_OUT_NEG_O,
  output reg  [`TRQ_W-1:0]       TORQUE_OUT_MAG_O,
  output reg  [3:1]              OUTPUT_TERMINAL_O,
  output reg  [`MON_W-1:0]       OUTPUT_SIGNAL_MONITOR_O
);

  // ************************************************************
  // input synchronisation
  // ************************************************************
  wire fwd_pin_s;
  wire rev_pin_s;

  ot_sync u_sync_fwd (
    .clk_i  (CLOCK_I),
    .rstn_i (RSTN_I),
    .d_i    (FWD_RUN_PROHIBIT_IN_I),
    .q_o    (fwd_pin_s)
  );

  ot_sync u_sync_rev (
    .clk_i  (CLOCK_I),
    .rstn_i (RSTN_I),
    .d_i    (REV_RUN_PROHIBIT_IN_I),
    .q_o    (rev_pin_s)
  );

  // ************************************************************
  // prohibit mapping
  // ************************************************************
  // returns 1 when the direction is prohibited; unknown codes read as not prohibited
  function prohibit_map;
    input [`MAP_W-1:0] map;
    input [`MAP_W-1:0] use_code;
    input [`MAP_W-1:0] inv_code;
    input              pin;
    begin
      if (map == `MAP_NOT_USED) begin
        prohibit_map = 1'b0;
      end else if (map == use_code) begin
        prohibit_map = pin;
      end else if (map == inv_code) begin
        prohibit_map = ~pin;
      end else begin
        prohibit_map = 1'b0;
      end
    end
  endfunction

  wire fwd_prohibit = prohibit_map(FWD_PROHIBIT_MAP_FIELD_I, `MAP_FWD_USE, `MAP_FWD_INV, fwd_pin_s);
  wire rev_prohibit = prohibit_map(REV_PROHIBIT_MAP_FIELD_I, `MAP_REV_USE, `MAP_REV_INV, rev_pin_s);
  wire any_prohibit = fwd_prohibit | rev_prohibit;

  // ************************************************************
  // stop sequencer
  // ************************************************************
  localparam [2:0] ST_RUN   = 3'h0;
  localparam [2:0] ST_SVOFF = 3'h1;
  localparam [2:0] ST_DECEL = 3'h2;
  localparam [2:0] ST_CLAMP = 3'h3;
  localparam [2:0] ST_COAST = 3'h4;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [1:0] mode_q;
  reg [1:0] mode_d;
  reg [2:0] entry_state;

  // ************************************************************
  // stop entry decode
  // ************************************************************
  // torque control ignores the mode field and always takes the servo-off path;
  // the undefined mode 3 falls back to the servo-off path
  always @* begin
    entry_state = ST_SVOFF;
    if (TORQUE_CONTROL_I) begin
      entry_state = ST_SVOFF;
    end else if (OVERTRAVEL_STOP_MODE_FIELD_I == `OT_MODE_DEC_ZC) begin
      entry_state = ST_DECEL;
    end else if (OVERTRAVEL_STOP_MODE_FIELD_I == `OT_MODE_DEC_CST) begin
      entry_state = ST_DECEL;
    end else begin
      entry_state = ST_SVOFF;
    end
  end

  // ************************************************************
  // stop state machine
  // ************************************************************
  always @* begin
    state_d = state_q;
    mode_d  = mode_q;
    case (state_q)
      ST_RUN: begin
        if (any_prohibit && MOTOR_RUNNING_I) begin
          mode_d  = OVERTRAVEL_STOP_MODE_FIELD_I;
          state_d = entry_state;
        end
      end
      ST_SVOFF: begin
        if (MOTOR_STOPPED_I) begin
          state_d = ST_COAST;
        end else if (!any_prohibit) begin
          state_d = ST_RUN;
        end
      end
      ST_DECEL: begin
        if (MOTOR_STOPPED_I) begin
          if (mode_q == `OT_MODE_DEC_ZC) begin
            state_d = ST_CLAMP;
          end else begin
            state_d = ST_COAST;
          end
        end
      end
      ST_CLAMP, ST_COAST: begin
        // released once the limit switch clears
        if (!any_prohibit) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // state and latched mode share the clock and reset but nothing else
  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // the mode is kept from entry so a later edit cannot change the ending
  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mode_q <= `OT_MODE_SVOFF;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ************************************************************
  // torque clamp
  // ************************************************************
  function [`TRQ_W-1:0] min_trq;
    input [`TRQ_W-1:0] a;
    input [`TRQ_W-1:0] b;
    begin
      min_trq = (a < b) ? a : b;
    end
  endfunction

  wire [`TRQ_W-1:0] fwd_lim_eff = min_trq(FWD_TORQUE_LIMIT_I, MOTOR_MAX_TORQUE_I);
  wire [`TRQ_W-1:0] rev_lim_eff = min_trq(REV_TORQUE_LIMIT_I, MOTOR_MAX_TORQUE_I);
  wire [`TRQ_W-1:0] estop_eff   = min_trq(EMERGENCY_STOP_TORQUE_I, MOTOR_MAX_TORQUE_I);

  // ************************************************************
  // direction select
  // ************************************************************
  // a prohibited direction gets no torque
  reg [`TRQ_W-1:0] act_lim;
  reg              dir_blocked;
  always @* begin
    act_lim     = fwd_lim_eff;
    dir_blocked = fwd_prohibit;
    if (TORQUE_REF_NEG_I) begin
      act_lim     = rev_lim_eff;
      dir_blocked = rev_prohibit;
    end else begin
      act_lim     = fwd_lim_eff;
      dir_blocked = fwd_prohibit;
    end
  end

  // flag at equality too, so a reference sitting on the limit reads limited
  reg              limited;
  reg [`TRQ_W-1:0] clamped;
  always @* begin
    limited = 1'b0;
    clamped = TORQUE_REF_MAG_I;
    if (TORQUE_REF_MAG_I >= act_lim) begin
      limited = 1'b1;
      clamped = act_lim;
    end
  end

  // ************************************************************
  // output terminals
  // ************************************************************
  // one slice per terminal; select code 0 routes the flag nowhere
  wire [3:1] clt_route;
  genvar t;
  generate
    for (t = 1; t <= 3; t = t + 1) begin : g_term
      assign clt_route[t] = limited && ({{(32-`SEL_W){1'b0}}, TORQUE_FLAG_OUTPUT_SELECT_I} == t);
    end
  endgenerate

  // ************************************************************
  // next values of the registered outputs
  // ************************************************************
  // the stop outputs come from state_d, so they change on the same edge as state_q and line up with it
  wire              fwd_allowed_d = ~fwd_prohibit;
  wire              rev_allowed_d = ~rev_prohibit;
  wire              stop_d        = (state_d != ST_RUN);
  wire              decel_d       = (state_d == ST_DECEL);
  wire              clamp_d       = (state_d == ST_CLAMP);
  wire              coast_d       = (state_d == ST_COAST);
  wire              svoff_d       = (state_d == ST_SVOFF);
  // emergency torque is offered only while decelerating in mode 1 or 2
  wire [`TRQ_W-1:0] stop_trq_d    = decel_d ? estop_eff : `TRQ_ZERO;
  // any stop or a prohibited direction removes drive torque
  wire              trq_kill_d    = stop_d | dir_blocked;
  wire [`TRQ_W-1:0] trq_mag_d     = trq_kill_d ? `TRQ_ZERO : clamped;
  wire [3:1]        terminal_d    = OTHER_TERMINAL_FUNCS_I | clt_route;
  wire [`MON_W-1:0] monitor_d     = {limited, OTHER_TERMINAL_FUNCS_I};

  // ************************************************************
  // registered outputs: direction flags
  // ************************************************************
  // reset reads as prohibited until the first edge; then the flags follow the map of the synchroniser outputs
  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      FWD_ALLOWED_O <= 1'b0;
      REV_ALLOWED_O <= 1'b0;
    end else begin
      FWD_ALLOWED_O <= fwd_allowed_d;
      REV_ALLOWED_O <= rev_allowed_d;
    end
  end

  // ************************************************************
  // registered outputs: stop indications
  // ************************************************************
  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      STOP_ACTIVE_O    <= 1'b0;
      DECEL_ACTIVE_O   <= 1'b0;
      ZERO_CLAMP_O     <= 1'b0;
      COAST_O          <= 1'b0;
      SERVO_OFF_STOP_O <= 1'b0;
      STOP_TORQUE_O    <= `TRQ_ZERO;
    end else begin
      STOP_ACTIVE_O    <= stop_d;
      DECEL_ACTIVE_O   <= decel_d;
      ZERO_CLAMP_O     <= clamp_d;
      COAST_O          <= coast_d;
      SERVO_OFF_STOP_O <= svoff_d;
      STOP_TORQUE_O    <= stop_trq_d;
    end
  end

  // ************************************************************
  // registered outputs: torque
  // ************************************************************
  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      TORQUE_OUT_NEG_O <= 1'b0;
      TORQUE_OUT_MAG_O <= `TRQ_ZERO;
    end else begin
      TORQUE_OUT_NEG_O <= TORQUE_REF_NEG_I;
      TORQUE_OUT_MAG_O <= trq_mag_d;
    end
  end

  // ************************************************************
  // registered outputs: terminals and monitor
  // ************************************************************
  always @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      OUTPUT_TERMINAL_O       <= 3'h0;
      OUTPUT_SIGNAL_MONITOR_O <= {`MON_W{1'b0}};
    end else begin
      OUTPUT_TERMINAL_O       <= terminal_d;
      OUTPUT_SIGNAL_MONITOR_O <= monitor_d;
    end
  end

endmodule // overtravel_torque_limit
`default_nettype wire

// File: test/ot_switch_model.sv
// limit switch pair model that drives the prohibit pins
`default_nettype none
module ot_switch_model (
  input  wire logic fwd_hit_i, rev_hit_i, nc_i,
  output wire logic fwd_pin_o, rev_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a closed contact pulls the pin to 0V, an open one leaves the pull-up high
  assign fwd_pin_o = fwd_hit_i ~^ nc_i;
  assign rev_pin_o = rev_hit_i ~^ nc_i;
endmodule // ot_switch_model
`default_nettype wire

// File: test/ottl_checker.sv
// port assertions for the overtravel and torque limit block
`default_nettype none
module ottl_checker (
  input wire logic       CLOCK_I, RSTN_I, TORQUE_REF_NEG_I, TORQUE_CONTROL_I, MOTOR_RUNNING_I, MOTOR_STOPPED_I,
  input wire logic       FWD_ALLOWED_O, STOP_ACTIVE_O, DECEL_ACTIVE_O, ZERO_CLAMP_O, COAST_O, SERVO_OFF_STOP_O,
  input wire logic [3:0] FWD_PROHIBIT_MAP_FIELD_I, OUTPUT_SIGNAL_MONITOR_O,
  input wire logic [1:0] OVERTRAVEL_STOP_MODE_FIELD_I, TORQUE_FLAG_OUTPUT_SELECT_I,
  input wire logic [9:0] FWD_TORQUE_LIMIT_I, MOTOR_MAX_TORQUE_I, TORQUE_REF_MAG_I, TORQUE_OUT_MAG_O, STOP_TORQUE_O,
  input wire logic [3:1] OTHER_TERMINAL_FUNCS_I, OUTPUT_TERMINAL_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);
  wire [9:0] lim = (FWD_TORQUE_LIMIT_I < MOTOR_MAX_TORQUE_I) ? FWD_TORQUE_LIMIT_I : MOTOR_MAX_TORQUE_I;
  fwd_clamp_a:
    assert property (!TORQUE_REF_NEG_I |=> TORQUE_OUT_MAG_O <= $past(lim)) else $error("forward clamp exceeded");
  // outputs read zero on the first edge after reset, so skip that one
  limit_flag_a:
    assert property ($past(RSTN_I) && !STOP_ACTIVE_O && !TORQUE_REF_NEG_I && TORQUE_REF_MAG_I >= lim
      && TORQUE_FLAG_OUTPUT_SELECT_I == 2'h1 |=> OUTPUT_TERMINAL_O[1] && OUTPUT_SIGNAL_MONITOR_O[3])
      else $error("limit flag missing");
  shared_or_a:
    assert property ($past(RSTN_I) |=> (OUTPUT_TERMINAL_O & $past(OTHER_TERMINAL_FUNCS_I))
      == $past(OTHER_TERMINAL_FUNCS_I) && OUTPUT_SIGNAL_MONITOR_O[2:0] == $past(OTHER_TERMINAL_FUNCS_I))
      else $error("terminal or lost");
  decel_end_a:
    assert property (DECEL_ACTIVE_O && MOTOR_STOPPED_I |=> !DECEL_ACTIVE_O && (ZERO_CLAMP_O || COAST_O))
      else $error("decel did not end");
  stop_torque_a:
    assert property (!DECEL_ACTIVE_O |-> STOP_TORQUE_O == 10'h000) else $error("stop torque outside decel");
  decel_entry_a:
    assert property ($rose(DECEL_ACTIVE_O) |-> $past(MOTOR_RUNNING_I) && !$past(TORQUE_CONTROL_I)
      && $past(OVERTRAVEL_STOP_MODE_FIELD_I) inside {2'h1, 2'h2}) else $error("bad decel entry");
  svoff_entry_a:
    assert property ($rose(STOP_ACTIVE_O) && ($past(TORQUE_CONTROL_I) || $past(OVERTRAVEL_STOP_MODE_FIELD_I) == 2'h0)
      |-> SERVO_OFF_STOP_O && !DECEL_ACTIVE_O) else $error("bad servo off entry");
  fwd_unused_a:
    assert property (FWD_PROHIBIT_MAP_FIELD_I == 4'h8 [*2] |=> FWD_ALLOWED_O) else $error("unused map blocks");
  cover property ($rose(ZERO_CLAMP_O));
  cover property ($rose(COAST_O));
  cover property (OUTPUT_SIGNAL_MONITOR_O[3]);
endmodule // ottl_checker
bind overtravel_torque_limit ottl_checker u_chk (.*);
`default_nettype wire

// File: test/overtravel_torque_limit_test.sv
// self-checking bench for the overtravel and torque limit block
`default_nettype none
`include "ottl_consts.vh"
module overtravel_torque_limit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK_I = 0, RSTN_I = 0, SERVO_OFF_STOP_MODE_FIELD_I = 0, TORQUE_CONTROL_I = 0, TORQUE_REF_NEG_I = 0;
  logic MOTOR_RUNNING_I = 0, MOTOR_STOPPED_I = 0, fwd_hit = 0, rev_hit = 0, nc = 1;
  logic [3:0] FWD_PROHIBIT_MAP_FIELD_I = `MAP_NOT_USED, REV_PROHIBIT_MAP_FIELD_I = `MAP_NOT_USED;
  logic [1:0] OVERTRAVEL_STOP_MODE_FIELD_I = 2'h0, TORQUE_FLAG_OUTPUT_SELECT_I = 2'h0;
  logic [9:0] EMERGENCY_STOP_TORQUE_I = `TRQ_DEFAULT, FWD_TORQUE_LIMIT_I = `TRQ_DEFAULT;
  logic [9:0] REV_TORQUE_LIMIT_I = `TRQ_DEFAULT, MOTOR_MAX_TORQUE_I = 10'h1F4, TORQUE_REF_MAG_I = 10'h000;
  logic [3:1] OTHER_TERMINAL_FUNCS_I = 3'h0;
  wire FWD_RUN_PROHIBIT_IN_I, REV_RUN_PROHIBIT_IN_I, FWD_ALLOWED_O, REV_ALLOWED_O, STOP_ACTIVE_O, DECEL_ACTIVE_O;
  wire ZERO_CLAMP_O, COAST_O, SERVO_OFF_STOP_O, TORQUE_OUT_NEG_O;
  wire [9:0] STOP_TORQUE_O, TORQUE_OUT_MAG_O;
  wire [3:1] OUTPUT_TERMINAL_O;
  wire [3:0] OUTPUT_SIGNAL_MONITOR_O;
  int failures = 0, tests_run = 0;
  overtravel_torque_limit DUT (.*);
  ot_switch_model switches (.fwd_hit_i(fwd_hit), .rev_hit_i(rev_hit), .nc_i(nc),
    .fwd_pin_o(FWD_RUN_PROHIBIT_IN_I), .rev_pin_o(REV_RUN_PROHIBIT_IN_I));
  always #5 CLOCK_I = ~CLOCK_I;
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge CLOCK_I);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // motor idle, so a prohibit only moves the allowed flags
  task automatic map_test;
    logic [3:0] fm [3] = '{`MAP_NOT_USED, `MAP_FWD_USE, `MAP_FWD_INV};
    logic [3:0] rm [3] = '{`MAP_NOT_USED, `MAP_REV_USE, `MAP_REV_INV};
    for (int i = 0; i < 3; i++)
      for (int h = 0; h < 2; h++) begin
        FWD_PROHIBIT_MAP_FIELD_I = fm[i];
        REV_PROHIBIT_MAP_FIELD_I = rm[i];
        nc = (i != 2);
        fwd_hit = h[0];
        rev_hit = !h[0];
        cyc(4);
        chk(FWD_ALLOWED_O === (i == 0 || !h[0]), "fwd allowed");
        chk(REV_ALLOWED_O === (i == 0 || h[0]), "rev allowed");
        chk(STOP_ACTIVE_O === 1'b0, "stop while idle");
      end
  endtask
  task automatic stop_test(input logic [1:0] mode, input logic tq);
    logic dec;
    dec = (mode == 2'h1 || mode == 2'h2) && !tq;
    // clear what the mapping scenario left behind before the motor runs
    FWD_PROHIBIT_MAP_FIELD_I = `MAP_FWD_USE;
    REV_PROHIBIT_MAP_FIELD_I = `MAP_NOT_USED;
    nc = 1'b1;
    fwd_hit = 1'b0;
    cyc(4);
    OVERTRAVEL_STOP_MODE_FIELD_I = mode;
    TORQUE_CONTROL_I = tq;
    MOTOR_RUNNING_I = 1'b1;
    TORQUE_REF_MAG_I = 10'h064;
    cyc(2);
    fwd_hit = 1'b1;
    cyc(4);
    chk(STOP_ACTIVE_O === 1'b1 && FWD_ALLOWED_O === 1'b0, "no stop");
    chk(DECEL_ACTIVE_O === dec && SERVO_OFF_STOP_O === !dec, "stop kind");
    chk(STOP_TORQUE_O === (dec ? 10'h1F4 : 10'h000), "stop torque");
    // the mode is held from entry, so a late change must not matter
    OVERTRAVEL_STOP_MODE_FIELD_I = 2'h0;
    MOTOR_RUNNING_I = 1'b0;
    MOTOR_STOPPED_I = 1'b1;
    cyc(2);
    chk(ZERO_CLAMP_O === (dec && mode == 2'h1) && COAST_O === !(dec && mode == 2'h1), "end state");
    fwd_hit = 1'b0;
    MOTOR_STOPPED_I = 1'b0;
    TORQUE_CONTROL_I = 1'b0;
    cyc(5);
    chk(STOP_ACTIVE_O === 1'b0 && FWD_ALLOWED_O === 1'b1, "no release");
  endtask
  task automatic torque_test;
    FWD_TORQUE_LIMIT_I = 10'h258;
    REV_TORQUE_LIMIT_I = 10'h0C8;
    TORQUE_REF_MAG_I = 10'h258;
    for (int s = 1; s < 4; s++) begin
      TORQUE_FLAG_OUTPUT_SELECT_I = s[1:0];
      TORQUE_REF_NEG_I = !s[0];
      cyc(2);
      chk(TORQUE_OUT_MAG_O === (s[0] ? 10'h1F4 : 10'h0C8) && TORQUE_OUT_NEG_O === !s[0], "clamp");
      chk(OUTPUT_TERMINAL_O === 3'(1 << (s - 1)) && OUTPUT_SIGNAL_MONITOR_O === 4'h8, "flag");
    end
    TORQUE_REF_MAG_I = 10'h064;
    OTHER_TERMINAL_FUNCS_I = 3'h5;
    cyc(2);
    chk(TORQUE_OUT_MAG_O === 10'h064 && OUTPUT_SIGNAL_MONITOR_O === 4'h5, "unlimited");
    TORQUE_REF_MAG_I = 10'h258;
    cyc(2);
    chk(OUTPUT_TERMINAL_O === 3'h5 && OUTPUT_SIGNAL_MONITOR_O === 4'hD, "shared");
  endtask
  initial begin
    cyc(5);
    RSTN_I = 1'b1;
    cyc(2);
    map_test();
    stop_test(2'h0, 1'b0);
    stop_test(2'h1, 1'b0);
    stop_test(2'h2, 1'b0);
    stop_test(2'h3, 1'b0);
    stop_test(2'h1, 1'b1);
    torque_test();
    complete_run();
  end
  initial begin
    #50000;
    failures++;
    complete_run();
  end
endmodule // overtravel_torque_limit_test
`default_nettype wire
